// ==== pkg/atx_map.vh ====
/*
 * Constants for the address and translation fault unit: cause codes,
 * vector offsets, address space classes, access kinds and register offsets.
 * Assumes inclusion by bare name from the design files.
 */
`ifndef ATX_MAP_VH
`define ATX_MAP_VH

// Exception codes written into the cause field.
`define ATX_CODE_MOD          5'h01
`define ATX_CODE_XLATE_FL     5'h02
`define ATX_CODE_XLATE_ST     5'h03
`define ATX_CODE_ADDR_FL      5'h04
`define ATX_CODE_ADDR_ST      5'h05

// Vector offsets from the exception base.
`define ATX_VEC_REFILL32      12'h000
`define ATX_VEC_REFILL64      12'h080
`define ATX_VEC_COMMON        12'h180

// Access kinds presented by the pipeline.
`define ATX_KIND_FETCH        2'h0
`define ATX_KIND_LOAD         2'h1
`define ATX_KIND_STORE        2'h2

// Access sizes.
`define ATX_SIZE_BYTE         2'h0
`define ATX_SIZE_HALF         2'h1
`define ATX_SIZE_WORD         2'h2
`define ATX_SIZE_DOUBLE       2'h3

// Operating modes.
`define ATX_MODE_KERNEL       2'h0
`define ATX_MODE_SUPER        2'h1
`define ATX_MODE_USER         2'h2

// Address space classes.
`define ATX_SPACE_USER        3'h0
`define ATX_SPACE_SUPER       3'h1
`define ATX_SPACE_KERNEL      3'h2
`define ATX_SPACE_KUNMAPPED   3'h3
`define ATX_SPACE_ILLEGAL     3'h4

// Register bus offsets (read view of captured state; the status register is also written).
`define ATX_REG_CAUSE         4'h0
`define ATX_REG_EPC_LO        4'h1
`define ATX_REG_EPC_HI        4'h2
`define ATX_REG_BADVA_LO      4'h3
`define ATX_REG_BADVA_HI      4'h4
`define ATX_REG_TAG_LO        4'h5
`define ATX_REG_TAG_HI        4'h6
`define ATX_REG_PTP_LO        4'h7
`define ATX_REG_PTP_HI        4'h8
`define ATX_REG_STATUS        4'h9
`define ATX_REG_VECTOR        4'hA
`define ATX_REG_CTX_LO        4'hB
`define ATX_REG_CTX_HI        4'hC

// Status register fields.
`define ATX_ST_KX             0
`define ATX_ST_SX             1
`define ATX_ST_UX             2
`define ATX_ST_EXL            3
`define ATX_ST_RESET          32'h0000_0000

`endif

// ==== logic/atx_classify.v ====
/*
 * Address space classifier and fault prioritiser for one reference.
 * Assumes the pipeline presents a registered reference and translation
 * lookup results in the same cycle; purely combinational.
 */
`include "atx_map.vh"
`timescale 1ns/1ps
`default_nettype none

module atx_classify (
  // Reference
  input  wire [63:0] vaddr,
  input  wire [1:0]  kind,
  input  wire [1:0]  size,
  input  wire [1:0]  mode,
  input  wire        kx,
  input  wire        sx,
  input  wire        ux,
  // Translation lookup
  input  wire        tlb_hit,
  input  wire        tlb_valid,
  input  wire        tlb_dirty,
  // Result
  output reg         fault,
  output reg  [4:0]  code,
  output reg         refill,
  output reg         wide_space,
  output reg         load_xlate
);

  reg [2:0] space;
  reg       misaligned;
  reg       priv_err;
  reg       is_store;

  // Classifies an address into user, supervisor, mapped or unmapped kernel, or illegal.
  function [2:0] seg_class;
    input [63:0] va;
    begin
      if (va[63:31] == 33'h0_0000_0000) begin
        seg_class = `ATX_SPACE_USER;
      end else if (va[63:31] == 33'h1_FFFF_FFFF) begin
        if (va[30:29] == 2'h2) begin
          seg_class = `ATX_SPACE_SUPER;
        end else if (va[30:29] == 2'h3) begin
          seg_class = `ATX_SPACE_KERNEL;
        end else begin
          seg_class = `ATX_SPACE_KUNMAPPED;
        end
      end else if (va[63:62] == 2'h0) begin
        seg_class = (va[61:40] == 22'h00_0000) ? `ATX_SPACE_USER : `ATX_SPACE_ILLEGAL;
      end else if (va[63:62] == 2'h1) begin
        seg_class = (va[61:40] == 22'h00_0000) ? `ATX_SPACE_SUPER : `ATX_SPACE_ILLEGAL;
      end else if (va[63:62] == 2'h2) begin
        seg_class = (va[61:40] == 22'h00_0000 || va[61:59] == 3'h0) ?
                    `ATX_SPACE_KUNMAPPED : `ATX_SPACE_ILLEGAL;
      end else begin
        seg_class = (va[61:40] < 22'h3F_FFFF) ? `ATX_SPACE_KERNEL : `ATX_SPACE_ILLEGAL;
      end
    end
  endfunction

  always @* begin
    space      = seg_class(vaddr);
    is_store   = (kind == `ATX_KIND_STORE);
    case (size)
      `ATX_SIZE_HALF:   misaligned = vaddr[0];
      `ATX_SIZE_WORD:   misaligned = |vaddr[1:0];
      `ATX_SIZE_DOUBLE: misaligned = |vaddr[2:0];
      default:          misaligned = 1'b0;
    endcase
    // Fetches are always word sized, whatever the size field carries.
    if (kind == `ATX_KIND_FETCH) begin
      misaligned = |vaddr[1:0];
    end
    priv_err = (space == `ATX_SPACE_ILLEGAL) ||
               (mode == `ATX_MODE_USER && space != `ATX_SPACE_USER) ||
               (mode == `ATX_MODE_SUPER &&
                (space == `ATX_SPACE_KERNEL || space == `ATX_SPACE_KUNMAPPED));
    // wide bit chosen by the address space, not the mode
    case (space)
      `ATX_SPACE_USER:  wide_space = ux;
      `ATX_SPACE_SUPER: wide_space = sx;
      default:          wide_space = kx;
    endcase
    fault      = 1'b0;
    code       = 5'h00;
    refill     = 1'b0;
    load_xlate = 1'b0;
    if (priv_err || misaligned) begin
      fault = 1'b1;
      code  = is_store ? `ATX_CODE_ADDR_ST : `ATX_CODE_ADDR_FL;
    // unmapped kernel never faults in translation
    end else if (space != `ATX_SPACE_KUNMAPPED) begin
      if (!tlb_hit) begin
        fault      = 1'b1;
        refill     = 1'b1;
        load_xlate = 1'b1;
        code       = is_store ? `ATX_CODE_XLATE_ST : `ATX_CODE_XLATE_FL;
      end else if (!tlb_valid) begin
        fault      = 1'b1;
        load_xlate = 1'b1;
        code       = is_store ? `ATX_CODE_XLATE_ST : `ATX_CODE_XLATE_FL;
      end else if (is_store && !tlb_dirty) begin
        fault      = 1'b1;
        load_xlate = 1'b1;
        code       = `ATX_CODE_MOD;
      end
    end
  end

endmodule

`default_nettype wire

// ==== logic/atx_fault_unit.v ====
/*
 * Address and translation fault unit: detects address errors and
 * translation faults, picks the vector and captures fault state.
 * Assumes the pipeline holds ref_valid for one cycle per reference and
 * supplies lookup results combinationally in that cycle; the handler
 * clears the exception level through the status register.
 */
`include "atx_map.vh"
`timescale 1ns/1ps
`default_nettype none

module atx_fault_unit (
  // Clock and reset
  input  wire        clock,
  input  wire        rstn,
  // Reference from the pipeline
  input  wire        ref_valid,
  input  wire [63:0] ref_vaddr,
  input  wire [1:0]  ref_kind,
  input  wire [1:0]  ref_size,
  input  wire [1:0]  ref_mode,
  input  wire [63:0] ref_pc,
  input  wire        ref_in_delay_slot,
  input  wire [63:0] ref_branch_pc,
  input  wire [7:0]  cur_asid,
  // Translation lookup result
  input  wire        tlb_hit,
  input  wire        tlb_valid,
  input  wire        tlb_dirty,
  input  wire [5:0]  tlb_wired,
  // Register port
  input  wire [3:0]  reg_addr,
  input  wire [31:0] reg_wdata,
  input  wire        reg_write,
  input  wire        reg_read,
  output reg  [31:0] reg_rdata,
  // Exception request to the pipeline
  output reg         exc_take,
  output reg  [11:0] exc_vector,
  output reg         exception_level_flag,
  output reg  [5:0]  random_index
);

  localparam [5:0] TLB_TOP = 6'h3F;

  reg         rst_s1_q;
  reg         rst_s2_q;
  wire        rst_n;

  reg  [4:0]  exception_code_field;
  reg         delay_slot_flag;
  reg  [63:0] exception_return_pc;
  reg  [63:0] faulting_address_reg;
  reg  [63:0] xlate_tag_staging;
  reg  [63:0] page_table_pointer_wide;
  reg  [63:0] page_table_pointer_narrow;
  reg         kernel_wide_addressing;
  reg         supervisor_wide_addressing;
  reg         user_wide_addressing;
  reg  [5:0]  random_d;

  wire        c_fault;
  wire [4:0]  c_code;
  wire        c_refill;
  wire        c_wide;
  wire        c_load_xlate;
  wire        take;
  reg  [11:0] vector_d;

  // Software write to the status register; both the mode bits and the level use it.
  function status_wr;
    input       we;
    input [3:0] addr;
    begin
      status_wr = we && (addr == `ATX_REG_STATUS);
    end
  endfunction

  // Reset release through two flops so deassertion is clean.
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      rst_s1_q <= 1'b0;
      rst_s2_q <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_s2_q <= rst_s1_q;
    end
  end
  assign rst_n = rst_s2_q;

  atx_classify u_classify (
    .vaddr      (ref_vaddr),
    .kind       (ref_kind),
    .size       (ref_size),
    .mode       (ref_mode),
    .kx         (kernel_wide_addressing),
    .sx         (supervisor_wide_addressing),
    .ux         (user_wide_addressing),
    .tlb_hit    (tlb_hit),
    .tlb_valid  (tlb_valid),
    .tlb_dirty  (tlb_dirty),
    .fault      (c_fault),
    .code       (c_code),
    .refill     (c_refill),
    .wide_space (c_wide),
    .load_xlate (c_load_xlate)
  );

  assign take = ref_valid && c_fault;

  always @* begin
    // dedicated vectors only at exception level zero
    if (c_refill && !exception_level_flag) begin
      // wide space picks the 64-bit vector
      vector_d = c_wide ? `ATX_VEC_REFILL64 : `ATX_VEC_REFILL32;
    end else begin
      vector_d = `ATX_VEC_COMMON;
    end
  end

  // Random index counts down through the unwired entries every cycle.
  // It wraps before stepping onto a wired entry, so it never names one.
  always @* begin
    if (random_index <= tlb_wired || (random_index - 6'h01) <= tlb_wired) begin
      random_d = TLB_TOP;
    end else begin
      random_d = random_index - 6'h01;
    end
  end

  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      exc_take                   <= 1'b0;
      exc_vector                 <= `ATX_VEC_COMMON;
      exception_level_flag       <= 1'b0;
      exception_code_field       <= 5'h00;
      delay_slot_flag            <= 1'b0;
      exception_return_pc        <= 64'h0000_0000_0000_0000;
      faulting_address_reg       <= 64'h0000_0000_0000_0000;
      xlate_tag_staging          <= 64'h0000_0000_0000_0000;
      page_table_pointer_wide    <= 64'h0000_0000_0000_0000;
      page_table_pointer_narrow  <= 64'h0000_0000_0000_0000;
      kernel_wide_addressing     <= 1'b0;
      supervisor_wide_addressing <= 1'b0;
      user_wide_addressing       <= 1'b0;
      random_index               <= TLB_TOP;
    end else begin
      exc_take   <= take;
      // The vector holds after the pulse so software can see where the last fault went.
      exc_vector <= take ? vector_d : exc_vector;
      // replacement index stays in the unwired range
      random_index <= random_d;
      if (status_wr(reg_write, reg_addr)) begin
        kernel_wide_addressing     <= reg_wdata[`ATX_ST_KX];
        supervisor_wide_addressing <= reg_wdata[`ATX_ST_SX];
        user_wide_addressing       <= reg_wdata[`ATX_ST_UX];
      end
      // A fault in the same cycle as a software clear keeps the level set.
      if (take) begin
        exception_level_flag <= 1'b1;
      end else if (status_wr(reg_write, reg_addr)) begin
        exception_level_flag <= reg_wdata[`ATX_ST_EXL];
      end
      if (take) begin
        exception_code_field <= c_code;
        faulting_address_reg <= ref_vaddr;
        if (!exception_level_flag) begin
          delay_slot_flag     <= ref_in_delay_slot;
          exception_return_pc <= ref_in_delay_slot ? ref_branch_pc : ref_pc;
        end
        // translation faults fill tag and pointers
        if (c_load_xlate) begin
          xlate_tag_staging       <= {ref_vaddr[63:13], 5'h00, cur_asid};
          page_table_pointer_wide <= {31'h0000_0000, ref_vaddr[63:62],
                                      ref_vaddr[39:13], 4'h0};
          // The narrow pointer only covers the 32-bit compatible page number.
          page_table_pointer_narrow <= {41'h0, ref_vaddr[31:13], 4'h0};
        end
      end
    end
  end

  // Read data appear in the cycle after the strobe; unmapped reads give zero.
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 32'h0000_0000;
    end else if (reg_read) begin
      case (reg_addr)
        `ATX_REG_CAUSE:    reg_rdata <= {delay_slot_flag, 24'h00_0000,
                                         exception_code_field, 2'h0};
        `ATX_REG_EPC_LO:   reg_rdata <= exception_return_pc[31:0];
        `ATX_REG_EPC_HI:   reg_rdata <= exception_return_pc[63:32];
        `ATX_REG_BADVA_LO: reg_rdata <= faulting_address_reg[31:0];
        `ATX_REG_BADVA_HI: reg_rdata <= faulting_address_reg[63:32];
        `ATX_REG_TAG_LO:   reg_rdata <= xlate_tag_staging[31:0];
        `ATX_REG_TAG_HI:   reg_rdata <= xlate_tag_staging[63:32];
        `ATX_REG_PTP_LO:   reg_rdata <= page_table_pointer_wide[31:0];
        `ATX_REG_PTP_HI:   reg_rdata <= page_table_pointer_wide[63:32];
        `ATX_REG_STATUS:   reg_rdata <= {28'h000_0000, exception_level_flag,
                                         user_wide_addressing,
                                         supervisor_wide_addressing,
                                         kernel_wide_addressing};
        `ATX_REG_VECTOR:   reg_rdata <= {20'h0_0000, exc_vector};
        `ATX_REG_CTX_LO:   reg_rdata <= page_table_pointer_narrow[31:0];
        `ATX_REG_CTX_HI:   reg_rdata <= page_table_pointer_narrow[63:32];
        default:           reg_rdata <= 32'h0000_0000;
      endcase
    end else begin
      reg_rdata <= 32'h0000_0000;
    end
  end

endmodule

`default_nettype wire

// ==== testbench/atx_fault_unit_properties.sv ====
/* Property checker for the fault unit, bound to its top module.
   Sees only the unit's ports; assumes tlb_wired stays steady. */
`timescale 1ns/1ps
`default_nettype none
`include "atx_map.vh"
module atx_fault_unit_properties (
  // Clock and reset
  input wire logic        clock,
  input wire logic        rstn,
  // Reference and lookup
  input wire logic        ref_valid,
  input wire logic [63:0] ref_vaddr,
  input wire logic [1:0]  ref_kind,
  input wire logic [1:0]  ref_size,
  input wire logic [1:0]  ref_mode,
  input wire logic        tlb_hit,
  input wire logic        tlb_valid,
  input wire logic        tlb_dirty,
  input wire logic [5:0]  tlb_wired,
  // Results
  input wire logic        exc_take,
  input wire logic [11:0] exc_vector,
  input wire logic        exception_level_flag,
  input wire logic [5:0]  random_index
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);
  // Aligned word reference in the low user segment, legal from every mode.
  wire logic low_ok = ref_valid && ref_vaddr[63:31] == 33'h0 && ref_vaddr[1:0] == 2'h0
    && ref_size == `ATX_SIZE_WORD;
  wire logic mis = ref_kind == `ATX_KIND_FETCH || ref_size == `ATX_SIZE_WORD ?
    ref_vaddr[1:0] != 2'h0 : ref_size == `ATX_SIZE_DOUBLE ? ref_vaddr[2:0] != 3'h0 :
    ref_size == `ATX_SIZE_HALF && ref_vaddr[0];
  AST_MISALIGN: assert property (ref_valid && mis |=> exc_take
    && exc_vector == `ATX_VEC_COMMON) else $error("misaligned reference missed");
  AST_USER_PRIV: assert property (ref_valid && ref_mode == `ATX_MODE_USER
    && ref_vaddr[63] |=> exc_take && exc_vector == `ATX_VEC_COMMON)
    else $error("user reference above user space missed");
  AST_UNMAPPED: assert property (ref_valid && ref_mode == `ATX_MODE_KERNEL
    && ref_vaddr[63:30] == {33'h1_FFFF_FFFF, 1'b0} && ref_vaddr[1:0] == 2'h0
    && ref_kind == `ATX_KIND_FETCH |=> !exc_take) else $error("unmapped window faulted");
  AST_REFILL_VEC: assert property (low_ok && !exception_level_flag && !tlb_hit
    |=> exc_take && exc_vector != `ATX_VEC_COMMON) else $error("refill vector wrong");
  AST_NESTED: assert property (low_ok && exception_level_flag && !tlb_hit
    |=> exc_take && exc_vector == `ATX_VEC_COMMON) else $error("nested refill vector wrong");
  AST_INVALID: assert property (low_ok && tlb_hit && !tlb_valid
    |=> exc_take && exc_vector == `ATX_VEC_COMMON) else $error("invalid entry missed");
  AST_MODIFIED: assert property (low_ok && ref_kind == `ATX_KIND_STORE && tlb_hit
    && tlb_valid && !tlb_dirty |=> exc_take && exc_vector == `ATX_VEC_COMMON)
    else $error("store to clean entry missed");
  AST_CLEAN: assert property (low_ok && tlb_hit && tlb_valid
    && (tlb_dirty || ref_kind != `ATX_KIND_STORE) |=> !exc_take) else $error("spurious fault");
  AST_EXL_SET: assert property (exc_take |-> exception_level_flag)
    else $error("fault left exception level clear");
  AST_RANDOM: assert property (random_index > tlb_wired)
    else $error("replacement index in wired range");
  COV_R32: cover property (exc_take && exc_vector == `ATX_VEC_REFILL32);
  COV_R64: cover property (exc_take && exc_vector == `ATX_VEC_REFILL64);
  COV_COMMON: cover property (exc_take && exc_vector == `ATX_VEC_COMMON);
endmodule
bind atx_fault_unit atx_fault_unit_properties u_props (.clock(clock), .rstn(rstn),
  .ref_valid(ref_valid), .ref_vaddr(ref_vaddr), .ref_kind(ref_kind), .ref_size(ref_size),
  .ref_mode(ref_mode), .tlb_hit(tlb_hit), .tlb_valid(tlb_valid), .tlb_dirty(tlb_dirty),
  .tlb_wired(tlb_wired), .exc_take(exc_take), .exc_vector(exc_vector),
  .exception_level_flag(exception_level_flag), .random_index(random_index));
`default_nettype wire

// ==== testbench/atx_xlate_model.sv ====
/* Stand-in for the translation lookup beside the fault unit.
   Assumes the bench names the outcome of each reference. */
`timescale 1ns/1ps
`default_nettype none
module atx_xlate_model (
  // Clock and control
  input  wire logic       clock,
  input  wire logic       active,
  input  wire logic [1:0] outcome,
  // Lookup result
  output var  logic       tlb_hit,
  output var  logic       tlb_valid,
  output var  logic       tlb_dirty
);
  logic [2:0] noise_q = 3'h5;
  // Between references the result means nothing, so it churns to expose misuse.
  always @(posedge clock) noise_q <= ~noise_q ^ {noise_q[1:0], 1'b1};
  // Outcome 0 miss, 1 invalid entry, 2 clean entry, 3 dirty entry.
  always_comb begin
    if (active) {tlb_hit, tlb_valid, tlb_dirty} = {outcome != 2'h0, outcome[1], &outcome};
    else {tlb_hit, tlb_valid, tlb_dirty} = noise_q;
  end
endmodule
`default_nettype wire

// ==== testbench/atx_fault_unit_tb.sv ====
/* Self-checking bench for the fault unit: corner references, then random ones.
   Assumes the lookup model answers in the cycle of the reference. */
`timescale 1ns/1ps
`default_nettype none
`include "atx_map.vh"
module atx_fault_unit_tb;
  logic        clock = 1'b0;
  logic        rstn = 1'b0;
  logic        ref_valid = 1'b0;
  logic [63:0] ref_vaddr = 64'h0;
  logic [1:0]  ref_kind = 2'h0;
  logic [1:0]  ref_size = 2'h0;
  logic [1:0]  ref_mode = 2'h0;
  logic [63:0] ref_pc = 64'h0;
  logic        ref_in_delay_slot = 1'b0;
  logic [63:0] ref_branch_pc = 64'h0;
  logic [7:0]  cur_asid = 8'h0;
  logic [5:0]  tlb_wired = 6'h15;
  logic [3:0]  reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic        reg_write = 1'b0;
  logic        reg_read = 1'b0;
  logic [1:0]  outcome = 2'h0;
  wire         tlb_hit, tlb_valid, tlb_dirty, exc_take, exception_level_flag;
  wire  [31:0] reg_rdata;
  wire  [11:0] exc_vector;
  wire  [5:0]  random_index;
  int          seed = 32'hc40e;
  int          mismatches = 0, num_checks = 0, cycles = 0, i, r;
  logic [2:0]  wide = 3'h0;
  logic        exl_now = 1'b0, exp_bd = 1'b0;
  logic [63:0] exp_epc = 64'h0, va;
  logic [31:0] rd;
  logic [19:0] c;
  // Corner fields: nested, {ux,sx,kx}, base, {kind,size}, {mode,outcome}.
  logic [19:0] corners [0:15] = '{20'h00068, 20'h100A8, 20'h04168, 20'h02324, 20'h02320,
    20'h00270, 20'h00720, 20'h0026B, 20'h01497, 20'h014A0, 20'h000A2, 20'h000AB,
    20'h0065A, 20'h00543, 20'h004A1, 20'h00029};
  logic [63:0] bases [0:15] = '{64'h0000_0000_1234_5670, 64'h0000_0010_0000_7000,
    64'hFFFF_FFFF_8000_1000, 64'hFFFF_FFFF_C000_2000, 64'hFFFF_FFFF_E000_3000,
    64'h0000_0100_0000_0000, 64'h0000_0000_1234_5671, 64'hFFFF_FFFF_A000_0008,
    64'h4000_0000_0000_4000, 64'h8000_0000_0000_5000, 64'hC000_0000_0000_6000,
    64'hFFFF_FF00_0000_0000, 64'h4000_0100_0000_0000, 64'h0000_0000_7FFF_FFF8,
    64'hFFFF_FFFF_9FFF_FFF0, 64'hFFFF_FFFF_FFFF_FFF0};

  atx_xlate_model lookup (.clock(clock), .active(ref_valid), .outcome(outcome),
    .tlb_hit(tlb_hit), .tlb_valid(tlb_valid), .tlb_dirty(tlb_dirty));
  atx_fault_unit uut (.clock(clock), .rstn(rstn), .ref_valid(ref_valid), .ref_vaddr(ref_vaddr),
    .ref_kind(ref_kind), .ref_size(ref_size), .ref_mode(ref_mode), .ref_pc(ref_pc),
    .ref_in_delay_slot(ref_in_delay_slot), .ref_branch_pc(ref_branch_pc), .cur_asid(cur_asid),
    .tlb_hit(tlb_hit), .tlb_valid(tlb_valid), .tlb_dirty(tlb_dirty), .tlb_wired(tlb_wired),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .exc_take(exc_take), .exc_vector(exc_vector),
    .exception_level_flag(exception_level_flag), .random_index(random_index));

  always #5 clock = ~clock;
  always @(posedge clock) begin
    cycles = cycles + 1;
    if (cycles == 20000) begin
      mismatches = mismatches + 1;
      test_done;
    end
  end

  task automatic test_done;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task automatic check(input logic [63:0] seen, input logic [63:0] want);
    num_checks = num_checks + 1;
    if (seen !== want) begin
      mismatches = mismatches + 1;
      $display("MISMATCH t=%0t seen %h want %h", $time, seen, want);
    end
  endtask

  task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clock);
    reg_write <= 1'b0;
  endtask

  task automatic reg_rd(input logic [3:0] a);
    @(posedge clock);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clock);
    reg_read <= 1'b0;
    #1 rd = reg_rdata;
  endtask

  task automatic set_status(input logic [2:0] w);
    wide = w;
    exl_now = 1'b0;
    reg_wr(`ATX_REG_STATUS, {29'h0, w});
  endtask

  // Returns {take, code, vector}; address errors outrank the translation faults.
  function automatic logic [17:0] expect_fault(input logic [63:0] a, input logic [1:0] k, s,
      m, o, input logic [2:0] w, input logic x);
    logic [2:0] sp;
    logic       wb;
    logic       bad;
    logic       st;
    wb = 1'b0;
    st = k == `ATX_KIND_STORE;
    sp = `ATX_SPACE_KUNMAPPED;
    if (a[63:40] == 24'h0) {sp, wb} = {`ATX_SPACE_USER, w[2]};
    // Wide regions below bit 40: supervisor, unmapped physical window, mapped kernel.
    else if (a[61:40] == 22'h0) {sp, wb} = a[63] ?
      {a[62] ? `ATX_SPACE_KERNEL : `ATX_SPACE_KUNMAPPED, w[0]} : {`ATX_SPACE_SUPER, w[1]};
    else if (a[63:31] != 33'h1_FFFF_FFFF) sp = `ATX_SPACE_ILLEGAL;
    else if (a[30:29] == 2'h2) {sp, wb} = {`ATX_SPACE_SUPER, w[1]};
    else if (a[30:29] == 2'h3) {sp, wb} = {`ATX_SPACE_KERNEL, w[0]};
    bad = sp == `ATX_SPACE_ILLEGAL || (m == `ATX_MODE_USER && sp != `ATX_SPACE_USER)
      || (m == `ATX_MODE_SUPER && sp >= `ATX_SPACE_KERNEL);
    if (k == `ATX_KIND_FETCH || s == `ATX_SIZE_WORD) bad |= a[1:0] != 2'h0;
    else if (s == `ATX_SIZE_DOUBLE) bad |= a[2:0] != 3'h0;
    else if (s == `ATX_SIZE_HALF) bad |= a[0];
    if (bad) return {1'b1, st ? `ATX_CODE_ADDR_ST : `ATX_CODE_ADDR_FL, `ATX_VEC_COMMON};
    if (sp == `ATX_SPACE_KUNMAPPED || o == 2'h3 || (o == 2'h2 && !st)) return 18'h0;
    if (o == 2'h2) return {1'b1, `ATX_CODE_MOD, `ATX_VEC_COMMON};
    if (o == 2'h1 || x) return {1'b1, st ? `ATX_CODE_XLATE_ST : `ATX_CODE_XLATE_FL, `ATX_VEC_COMMON};
    return {1'b1, st ? `ATX_CODE_XLATE_ST : `ATX_CODE_XLATE_FL,
      wb ? `ATX_VEC_REFILL64 : `ATX_VEC_REFILL32};
  endfunction

  task automatic run_ref(input logic [63:0] a, input logic [1:0] k, s, m, o);
    logic [17:0]  e;
    logic [63:0]  pc;
    logic [319:0] cap;
    int           j;
    e = expect_fault(a, k, s, m, o, wide, exl_now);
    pc = {$random(seed), $random(seed)};
    j = $random(seed);
    @(posedge clock);
    ref_valid <= 1'b1;
    ref_vaddr <= a;
    ref_kind <= k;
    ref_size <= s;
    ref_mode <= m;
    outcome <= o;
    ref_pc <= pc;
    ref_in_delay_slot <= j[0];
    ref_branch_pc <= pc - 64'h4;
    cur_asid <= pc[7:0];
    @(posedge clock);
    ref_valid <= 1'b0;
    #1;
    check(exc_take, e[17]);
    check(random_index > tlb_wired, 1'b1);
    if (e[17]) begin
      check(exc_vector, e[11:0]);
      // A fault taken inside a handler must not lose the outer return point.
      if (!exl_now) begin
        exp_epc = j[0] ? pc - 64'h4 : pc;
        exp_bd = j[0];
      end
      exl_now = 1'b1;
      // Narrow pointer, wide pointer and tag are only defined after translation faults.
      cap = {41'h0, a[31:13], 4'h0, 31'h0, a[63:62], a[39:13], 4'h0,
        a[63:13], 5'h0, pc[7:0], a, exp_epc};
      reg_rd(`ATX_REG_CAUSE);
      check({rd[31], rd[6:2]}, {exp_bd, e[16:12]});
      for (j = 0; j < (e[16:12] < `ATX_CODE_ADDR_FL ? 10 : 4); j++) begin
        reg_rd(j < 8 ? `ATX_REG_EPC_LO + j[3:0] : `ATX_REG_CTX_LO + j[3:0] - 4'h8);
        check(rd, cap[32 * j +: 32]);
      end
      reg_rd(`ATX_REG_STATUS);
      check(rd[3:0], {1'b1, wide});
    end
  endtask

  initial begin
    repeat (4) @(posedge clock);
    rstn <= 1'b1;
    repeat (3) @(posedge clock);
    reg_rd(`ATX_REG_STATUS);
    check(rd, `ATX_ST_RESET);
    reg_rd(4'hF);
    check(rd, 32'h0);
    for (i = 0; i < 216; i++) begin
      r = $random(seed);
      c = i < 16 ? corners[i] : r[19:0];
      if (c[3:2] == 2'h3) c[3:2] = `ATX_MODE_USER;
      if (c[7:6] == 2'h3) c[7:6] = `ATX_KIND_STORE;
      if (!c[16]) set_status(c[14:12]);
      va = bases[c[11:8]] + {61'h0, c[19:17]};
      // Wide user addresses are legal in either setting; the bench only uses them with wide user addressing on.
      if (!wide[2]) va[36] = 1'b0;
      run_ref(va, c[7:6], c[5:4], c[3:2], c[1:0]);
    end
    test_done;
  end
endmodule
`default_nettype wire
